// *** design/smbs_regs.svh ***
// Mode register field positions, codes, reset values, full-row column count and FIFO depth.
`ifndef SMBS_REGS_SVH
`define SMBS_REGS_SVH
`define SMBS_BURST_LO 0
`define SMBS_BURST_HI 2
`define SMBS_BT_BIT 3
`define SMBS_RL_LO 4
`define SMBS_RL_HI 6
`define SMBS_OPM_LO 7
`define SMBS_OPM_HI 8
`define SMBS_WB_BIT 9
`define SMBS_BURST_1 3'h0
`define SMBS_BURST_2 3'h1
`define SMBS_BURST_4 3'h2
`define SMBS_BURST_8 3'h3
`define SMBS_BURST_FULL 3'h7
`define SMBS_RL_1 3'h1
`define SMBS_RL_2 3'h2
`define SMBS_RL_3 3'h3
`define SMBS_OPM_NORMAL 2'h0
`define SMBS_MR_RESET 14'h0000
`define SMBS_EMR_RESET 14'h2000
`define SMBS_EMR_SEL 2'h2
`define SMBS_MR_SEL 2'h0
`define SMBS_TSR_LO 3
`define SMBS_TSR_HI 4
`define SMBS_FULL_COLS 10'h200
`define SMBS_FIFO_DEPTH 16
`endif

// *** design/smbs_pkg.sv ***
// Types shared by the burst sequencer files.
package smbs_pkg;
  typedef enum logic [2:0] {
    SMBS_CMD_NOP = 3'h0,
    SMBS_CMD_READ = 3'h1,
    SMBS_CMD_WRITE = 3'h2,
    SMBS_CMD_STOP = 3'h3,
    SMBS_CMD_LOAD = 3'h4
  } smbs_cmd_t;
  typedef struct packed {
    smbs_cmd_t cmd;
    logic [1:0] bank;
    logic [11:0] addr;
  } smbs_req_t;
  typedef struct packed {
    logic wr;
    logic [1:0] bank;
    logic [8:0] col;
  } smbs_acc_t;
  typedef enum logic [1:0] {
    SMBS_IDLE = 2'b00,
    SMBS_RUN = 2'b01,
    SMBS_LAST = 2'b11
  } smbs_state_t;
endpackage

// *** design/smbs_fifo.sv ***
// Parameterised flip-flop FIFO with valid and ready on both sides.
`timescale 1ns/100ps
module smbs_fifo #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 16
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [WIDTH-1:0] o_out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wp_q;
  logic [AW-1:0] rp_q;
  logic [AW:0] cnt_q;
  logic push;
  logic pop;
  assign o_in_ready = (cnt_q != (AW+1)'(DEPTH));
  assign o_out_valid = (cnt_q != '0);
  assign o_out_data = mem_q[rp_q];
  assign push = i_in_valid && o_in_ready;
  assign pop = o_out_valid && i_out_ready;
  always_ff @(posedge i_clk) begin
    if (push) begin
      mem_q[wp_q] <= i_in_data;
    end
  end
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wp_q <= wp_q + 1'b1;
      end
      if (pop) begin
        rp_q <= rp_q + 1'b1;
      end
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

// *** design/smbs_latency.sv ***
// Read latency pipe that marks the drive-start and data-valid edges.
`timescale 1ns/100ps
module smbs_latency (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_rd,
  input wire logic [1:0] i_lat,
  output logic o_drive,
  output logic o_valid
);
  logic [2:0] sh_q;
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      sh_q <= 3'h0;
    end else begin
      sh_q <= {sh_q[1:0], i_rd};
    end
  end
  // Drive starts one edge ahead of valid data.
  always_comb begin
    o_valid = 1'b0;
    o_drive = 1'b0;
    unique case (i_lat)
      2'h1: begin
        o_valid = sh_q[0];
        o_drive = i_rd;
      end
      2'h2: begin
        o_valid = sh_q[1];
        o_drive = sh_q[0];
      end
      2'h3: begin
        o_valid = sh_q[2];
        o_drive = sh_q[1];
      end
      default: begin
        o_valid = 1'b0;
        o_drive = 1'b0;
      end
    endcase
  end
endmodule

// *** design/smbs_seq.sv ***
// Mode register controlled column burst sequencer of a four-bank SDRAM.
`timescale 1ns/100ps
`include "smbs_regs.svh"
// Behaviour
// [RQ1] Burst lengths 1,2,4,8 both orders; full row only sequential.
// [RQ2] Full-row burst ends when the burst stop command arrives.
// [RQ3] Burst accesses wrap inside an aligned block of burst length.
// [RQ4] Upper column bits choose the block; low bits give the start.
// [RQ5] Mode bit 3 picks sequential or interleaved order.
// [RQ6] Sequential adds count, interleaved XORs count, modulo burst length.
// [RQ7] Full row starts at column, walks 512 columns, wraps in row.
// [RQ8] Length one touches one column and ignores the order bit.
// [RQ9] Read latency is one, two or three clocks.
// [RQ10] Read at edge n drives from n+m-1, valid by n+m.
// [RQ11] Controller keeps latency within the allowed clock rates.
// [RQ12] Operating mode bits 7 and 8 zero select normal operation.
// [RQ13] Controller avoids reserved codes and test modes; the bench also loads reserved length and latency codes.
// [RQ14] Write burst bit one makes every write a single access.
// [RQ15] Burst length comes from mode bits 0 to 2.
// [RQ16] Extended register defaults: 85 degree refresh, full drive, full array.
// [RQ17] Load with bank bits 1,0 equal 1,0 writes the extended register.
// [RQ18] Controller writes extended bits 6 to 11 as zero.
// [RQ19] Controller loads extended register only when idle, then waits.
// [RQ20] Extended register survives deep power-down.
// [RQ21] Read latency comes from mode bits 4 to 6.
// [RQ22] Load captures the opcode from address bits 0 to 11.
// [RQ23] Extended bits 3 and 4 pick the refresh temperature range.
// [RQ24] Length codes 0,1,2,3 mean 1,2,4,8; code 7 is full row.
// [RQ25] Latency codes 1,2,3 mean one, two, three clocks.
module smbs_seq (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire smbs_pkg::smbs_req_t i_req,
  input wire logic i_dpd,
  output smbs_pkg::smbs_acc_t o_acc,
  output logic o_acc_valid,
  output logic o_dq_oe,
  output logic o_rd_valid,
  output logic o_busy,
  output logic [13:0] o_mode,
  output logic [13:0] o_ext_mode,
  output logic [1:0] o_tsr,
  output logic o_normal
);
  smbs_pkg::smbs_state_t state_q;
  logic [13:0] mr_q;
  logic [13:0] emr_q;
  smbs_pkg::smbs_acc_t start_q;
  logic [8:0] cnt_q;
  logic [9:0] len_q;
  logic ilv_q;
  logic wr_q;
  logic stop;
  logic rd_cmd;
  logic wr_cmd;
  logic load_cmd;
  logic [9:0] blen;
  logic [9:0] wlen;
  logic [8:0] col_next;
  logic fifo_valid;
  logic fifo_ready;
  logic [11:0] fifo_data;
  logic lat_drive;
  logic lat_valid;
  logic dq_oe_q;
  logic rd_valid_q;
  logic [1:0] lat_code;

  // Burst length code to length in columns; zero marks a reserved code.
  function automatic logic [9:0] burst_decode(input logic [2:0] code);
    logic [9:0] r;
    r = 10'h000;
    unique case (code)
      `SMBS_BURST_1: r = 10'h001; // RQ24
      `SMBS_BURST_2: r = 10'h002;
      `SMBS_BURST_4: r = 10'h004;
      `SMBS_BURST_8: r = 10'h008;
      `SMBS_BURST_FULL: r = `SMBS_FULL_COLS; // RQ7
      default: r = 10'h000;
    endcase
    return r;
  endfunction

  // Read latency code to clocks; zero marks a reserved code.
  function automatic logic [1:0] rl_decode(input logic [2:0] code);
    logic [1:0] r;
    r = 2'h0;
    unique case (code)
      `SMBS_RL_1: r = 2'h1; // RQ25
      `SMBS_RL_2: r = 2'h2;
      `SMBS_RL_3: r = 2'h3;
      default: r = 2'h0;
    endcase
    return r;
  endfunction

  // Column at step k: aligned block kept, low bits stepped or XORed.
  function automatic logic [8:0] col_at(input logic [8:0] c, input logic [8:0] k,
                                        input logic [9:0] len, input logic ilv);
    logic [8:0] m;
    logic [8:0] lo;
    m = 9'(len - 10'h001);
    lo = ilv ? ((c ^ k) & m) : ((c + k) & m); // RQ6
    return (c & ~m) | lo; // RQ3 RQ4
  endfunction

  assign rd_cmd = (i_req.cmd == smbs_pkg::SMBS_CMD_READ);
  assign wr_cmd = (i_req.cmd == smbs_pkg::SMBS_CMD_WRITE);
  assign load_cmd = (i_req.cmd == smbs_pkg::SMBS_CMD_LOAD);
  assign stop = (i_req.cmd == smbs_pkg::SMBS_CMD_STOP);
  assign blen = burst_decode(mr_q[`SMBS_BURST_HI:`SMBS_BURST_LO]); // RQ15
  assign wlen = mr_q[`SMBS_WB_BIT] ? 10'h001 : blen; // RQ14
  assign lat_code = rl_decode(mr_q[`SMBS_RL_HI:`SMBS_RL_LO]); // RQ21 RQ25

  // Mode register load; the extended register keeps its value through deep power-down.
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      mr_q <= `SMBS_MR_RESET;
    end else if (load_cmd && i_req.bank == `SMBS_MR_SEL) begin
      mr_q <= {2'h0, i_req.addr}; // RQ22
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      emr_q <= `SMBS_EMR_RESET; // RQ16
    end else if (load_cmd && i_req.bank == `SMBS_EMR_SEL) begin
      emr_q <= {i_req.bank, i_req.addr}; // RQ17 RQ20
    end
  end

  // Burst capture and stepping.
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      state_q <= smbs_pkg::SMBS_IDLE;
      cnt_q <= 9'h000;
      len_q <= 10'h001;
      ilv_q <= 1'b0;
      wr_q <= 1'b0;
      start_q <= '0;
    end else if ((rd_cmd || wr_cmd) && blen != 10'h000) begin
      start_q <= '{wr: wr_cmd, bank: i_req.bank, col: i_req.addr[8:0]};
      wr_q <= wr_cmd;
      len_q <= wr_cmd ? wlen : blen; // RQ1
      // Full row is never interleaved; length one has no order.
      ilv_q <= mr_q[`SMBS_BT_BIT] && blen != `SMBS_FULL_COLS && blen != 10'h001; // RQ5 RQ8
      cnt_q <= 9'h000;
      state_q <= smbs_pkg::SMBS_RUN;
    end else if (stop) begin
      state_q <= smbs_pkg::SMBS_IDLE; // RQ2
    end else if (state_q == smbs_pkg::SMBS_RUN && fifo_ready) begin
      cnt_q <= cnt_q + 9'h001;
      if (len_q == `SMBS_FULL_COLS) begin
        state_q <= smbs_pkg::SMBS_RUN; // RQ7
      end else if (10'(cnt_q) + 10'h001 >= len_q) begin
        state_q <= smbs_pkg::SMBS_IDLE;
      end
    end
  end

  assign col_next = col_at(start_q.col, cnt_q, len_q, ilv_q);

  smbs_fifo #(
    .WIDTH(12),
    .DEPTH(`SMBS_FIFO_DEPTH)
  ) u_fifo (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_in_valid(state_q == smbs_pkg::SMBS_RUN),
    .o_in_ready(fifo_ready),
    .i_in_data({wr_q, start_q.bank, col_next}),
    .o_out_valid(fifo_valid),
    .i_out_ready(1'b1),
    .o_out_data(fifo_data)
  );

  smbs_latency u_lat (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_rd(rd_cmd),
    .i_lat(lat_code),
    .o_drive(lat_drive),
    .o_valid(lat_valid)
  );

  // Access stream leaves the FIFO through a register.
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_acc <= '0;
      o_acc_valid <= 1'b0;
    end else begin
      o_acc <= fifo_data;
      o_acc_valid <= fifo_valid;
    end
  end

  // Read data drive and first data valid, one edge apart.
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      dq_oe_q <= 1'b0;
      rd_valid_q <= 1'b0;
    end else begin
      dq_oe_q <= lat_drive; // RQ9 RQ10 RQ21 RQ25
      rd_valid_q <= lat_valid;
    end
  end
  assign o_dq_oe = dq_oe_q;
  assign o_rd_valid = rd_valid_q;

  // Burst activity flag.
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_busy <= 1'b0;
    end else begin
      o_busy <= (state_q != smbs_pkg::SMBS_IDLE);
    end
  end

  // Register mirrors and decoded status fields.
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_mode <= `SMBS_MR_RESET;
      o_ext_mode <= `SMBS_EMR_RESET;
      o_tsr <= 2'h0;
      o_normal <= 1'b1;
    end else begin
      o_mode <= mr_q;
      o_ext_mode <= emr_q;
      o_tsr <= emr_q[`SMBS_TSR_HI:`SMBS_TSR_LO]; // RQ23
      o_normal <= (mr_q[`SMBS_OPM_HI:`SMBS_OPM_LO] == `SMBS_OPM_NORMAL); // RQ12
    end
  end

  a_emr_load: assert property (@(posedge i_clk) disable iff (i_rst) // RQ17
    load_cmd && i_req.bank == 2'h2 |=> emr_q[11:0] == $past(i_req.addr))
    else $error("extended register not loaded");
  a_mr_keep: assert property (@(posedge i_clk) disable iff (i_rst) // RQ22
    load_cmd && i_req.bank == 2'h2 |=> $stable(mr_q))
    else $error("mode register disturbed by extended load");
  a_stop_ends: assert property (@(posedge i_clk) disable iff (i_rst) // RQ2
    stop && !rd_cmd |=> state_q == smbs_pkg::SMBS_IDLE)
    else $error("burst not stopped");
  a_block_wrap: assert property (@(posedge i_clk) disable iff (i_rst) // RQ3
    state_q == smbs_pkg::SMBS_RUN |->
    ((col_next ^ start_q.col) & ~9'(len_q - 10'h001)) == 9'h000)
    else $error("column left its block");
  a_single_wr: assert property (@(posedge i_clk) disable iff (i_rst) // RQ14
    wr_cmd && mr_q[9] && blen != 10'h000 |=> len_q == 10'h001)
    else $error("write not single");

  // Read latency pipe checks; a load right behind the read would change the latency.
  sequence s_rd_lat1;
    rd_cmd && lat_code == 2'h1;
  endsequence
  sequence s_rd_lat2;
    rd_cmd && lat_code == 2'h2 ##1 !load_cmd;
  endsequence
  sequence s_rd_lat3;
    rd_cmd && lat_code == 2'h3 ##1 !load_cmd ##1 !load_cmd;
  endsequence
  sequence s_drive_valid;
    lat_drive ##1 lat_valid;
  endsequence
  a_lat_one: assert property (@(posedge i_clk) disable iff (i_rst) // RQ9
    s_rd_lat1 |-> s_drive_valid)
    else $error("latency one timing wrong");
  a_lat_two: assert property (@(posedge i_clk) disable iff (i_rst) // RQ10
    s_rd_lat2 |-> s_drive_valid)
    else $error("latency two timing wrong");
  a_lat_three: assert property (@(posedge i_clk) disable iff (i_rst) // RQ21
    s_rd_lat3 |-> s_drive_valid)
    else $error("latency three timing wrong");
  a_full_seq: assert property (@(posedge i_clk) disable iff (i_rst) // RQ7
    state_q == smbs_pkg::SMBS_RUN && len_q == 10'h200 |-> !ilv_q)
    else $error("full row interleaved");
  a_first_col: assert property (@(posedge i_clk) disable iff (i_rst) // RQ4
    state_q == smbs_pkg::SMBS_RUN && cnt_q == 9'h000 |-> col_next == start_q.col)
    else $error("first column wrong");
  a_lat_reserved: assert property (@(posedge i_clk) disable iff (i_rst) // RQ25
    lat_code == 2'h0 |-> !lat_drive && !lat_valid)
    else $error("reserved latency gave read timing");
  a_dq_follow: assert property (@(posedge i_clk) disable iff (i_rst) // RQ10
    lat_drive |=> o_dq_oe)
    else $error("drive enable not registered");
  a_rd_follow: assert property (@(posedge i_clk) disable iff (i_rst) // RQ10
    lat_valid |=> o_rd_valid)
    else $error("data valid not registered");

  // Register load and retention checks.
  a_dpd_keep: assert property (@(posedge i_clk) disable iff (i_rst) // RQ20
    i_dpd && !(load_cmd && i_req.bank == `SMBS_EMR_SEL) |=> $stable(emr_q))
    else $error("extended register lost in deep power-down");
  a_mr_load: assert property (@(posedge i_clk) disable iff (i_rst) // RQ22
    load_cmd && i_req.bank == `SMBS_MR_SEL |=> mr_q == {2'h0, $past(i_req.addr)})
    else $error("mode register not loaded");
  a_other_bank: assert property (@(posedge i_clk) disable iff (i_rst) // RQ17
    load_cmd && i_req.bank[0] |=> $stable(emr_q) && $stable(mr_q))
    else $error("load with odd bank select changed a register");
  a_emr_sel: assert property (@(posedge i_clk) disable iff (i_rst) // RQ17
    load_cmd && i_req.bank == `SMBS_EMR_SEL |=> emr_q[13:12] == `SMBS_EMR_SEL)
    else $error("extended register select bits wrong");
  a_mode_mirror: assert property (@(posedge i_clk) disable iff (i_rst) // RQ22
    1'b1 |=> o_mode == $past(mr_q) && o_ext_mode == $past(emr_q))
    else $error("register mirror wrong");
  a_normal_flag: assert property (@(posedge i_clk) disable iff (i_rst) // RQ12
    1'b1 |=> o_normal == ($past(mr_q[`SMBS_OPM_HI:`SMBS_OPM_LO]) == `SMBS_OPM_NORMAL))
    else $error("normal mode flag wrong");
  a_tsr_field: assert property (@(posedge i_clk) disable iff (i_rst) // RQ23
    1'b1 |=> o_tsr == $past(emr_q[`SMBS_TSR_HI:`SMBS_TSR_LO]))
    else $error("refresh temperature field wrong");

  // Burst stepping checks.
  a_burst_len: assert property (@(posedge i_clk) disable iff (i_rst) // RQ1
    state_q == smbs_pkg::SMBS_RUN && len_q != `SMBS_FULL_COLS |-> 10'(cnt_q) < len_q)
    else $error("burst ran past its length");
  a_row_wrap: assert property (@(posedge i_clk) disable iff (i_rst) // RQ7
    state_q == smbs_pkg::SMBS_RUN && len_q == `SMBS_FULL_COLS |-> col_next == start_q.col + cnt_q)
    else $error("full row column wrong");
  a_seq_order: assert property (@(posedge i_clk) disable iff (i_rst) // RQ6
    state_q == smbs_pkg::SMBS_RUN && !ilv_q |->
    ((col_next - start_q.col) & 9'(len_q - 10'h001)) == (cnt_q & 9'(len_q - 10'h001)))
    else $error("sequential order wrong");
  a_ilv_order: assert property (@(posedge i_clk) disable iff (i_rst) // RQ6
    state_q == smbs_pkg::SMBS_RUN && ilv_q |->
    ((col_next ^ start_q.col) & 9'(len_q - 10'h001)) == (cnt_q & 9'(len_q - 10'h001)))
    else $error("interleaved order wrong");
  a_single_col: assert property (@(posedge i_clk) disable iff (i_rst) // RQ8
    state_q == smbs_pkg::SMBS_RUN && len_q == 10'h001 |-> col_next == start_q.col)
    else $error("single access column wrong");
  a_order_bit: assert property (@(posedge i_clk) disable iff (i_rst) // RQ5
    (rd_cmd || wr_cmd) && blen > 10'h001 && blen < `SMBS_FULL_COLS |=>
    ilv_q == $past(mr_q[`SMBS_BT_BIT]))
    else $error("burst order not taken from mode bit");
  a_write_len: assert property (@(posedge i_clk) disable iff (i_rst) // RQ14
    wr_cmd && !mr_q[`SMBS_WB_BIT] && blen != 10'h000 |=> len_q == $past(blen))
    else $error("write burst length wrong");
  a_len_reserved: assert property (@(posedge i_clk) disable iff (i_rst) // RQ24
    (rd_cmd || wr_cmd) && blen == 10'h000 && state_q == smbs_pkg::SMBS_IDLE |=>
    state_q == smbs_pkg::SMBS_IDLE)
    else $error("reserved length started a burst");
  a_busy_flag: assert property (@(posedge i_clk) disable iff (i_rst) // RQ2
    stop |=> ##1 !o_busy)
    else $error("busy flag still set after stop");
  a_acc_out: assert property (@(posedge i_clk) disable iff (i_rst) // RQ1
    fifo_valid |=> o_acc_valid && o_acc == $past(fifo_data))
    else $error("access not passed to the output");
endmodule

// *** testbench/smbs_ctl.sv ***
// Controller model that drives commands into the burst sequencer.
`timescale 1ns/100ps
module smbs_ctl (
  input wire logic i_clk,
  output smbs_pkg::smbs_req_t o_req
);
  initial o_req = '0;
  // Callers use normal mode and latency limits fit for this clock; the bench also loads reserved length and latency codes.
  // Extended loads carry zero in bits 6 to 11 and come only while idle.
  task automatic cmd(input smbs_pkg::smbs_cmd_t c, input logic [1:0] b,
                     input logic [11:0] a);
    @(posedge i_clk);
    o_req <= '{c, b, a};
    @(posedge i_clk);
    o_req <= '{smbs_pkg::SMBS_CMD_NOP, 2'h0, 12'h000};
  endtask
endmodule

// *** testbench/sdram_mode_burst_sequencer_tb.sv ***
// Self-checking bench of the burst sequencer.
`timescale 1ns/100ps
module sdram_mode_burst_sequencer_tb;
  typedef struct {logic [11:0] mr; logic [8:0] col; logic wr; int n;} smbs_row_t;
  logic i_clk, i_rst, i_dpd;
  smbs_pkg::smbs_req_t req;
  smbs_pkg::smbs_acc_t o_acc, q[$], e;
  logic o_acc_valid, o_dq_oe, o_rd_valid, o_busy, o_normal;
  logic [13:0] o_mode, o_ext_mode;
  logic [1:0] o_tsr;
  int failures = 0, n_checks = 0, cyc = 0, t, t_oe, t_rv, t_acc, len;
  smbs_row_t rows[7] = '{
    '{12'h028, 9'h0a5, 1'b0, 1}, '{12'h021, 9'h013, 1'b0, 2},
    '{12'h02a, 9'h0f1, 1'b0, 4}, '{12'h023, 9'h1fd, 1'b0, 8},
    '{12'h02b, 9'h036, 1'b0, 8}, '{12'h222, 9'h007, 1'b1, 1},
    '{12'h023, 9'h102, 1'b1, 8}};
  smbs_ctl ctl (.i_clk(i_clk), .o_req(req));
  smbs_seq dut (.i_clk(i_clk), .i_rst(i_rst), .i_req(req), .i_dpd(i_dpd),
    .o_acc(o_acc), .o_acc_valid(o_acc_valid), .o_dq_oe(o_dq_oe),
    .o_rd_valid(o_rd_valid), .o_busy(o_busy), .o_mode(o_mode),
    .o_ext_mode(o_ext_mode), .o_tsr(o_tsr), .o_normal(o_normal));
  initial begin
    i_clk = 1'b0;
    forever #12.5 i_clk = ~i_clk;
  end
  always @(posedge i_clk) cyc <= cyc + 1;
  always @(negedge i_clk) begin
    if (o_acc_valid === 1'b1) begin
      if (q.size() == 0) t_acc = cyc;
      q.push_back(o_acc);
    end
    if (o_dq_oe === 1'b1) t_oe = cyc;
    if (o_rd_valid === 1'b1) t_rv = cyc;
  end
  task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic results();
    if (failures == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic load(input logic [1:0] b, input logic [11:0] a);
    ctl.cmd(smbs_pkg::SMBS_CMD_LOAD, b, a);
    repeat (3) @(negedge i_clk);
  endtask
  task automatic burst(input logic wr, input logic [1:0] b, input logic [8:0] c);
    q.delete();
    ctl.cmd(wr ? smbs_pkg::SMBS_CMD_WRITE : smbs_pkg::SMBS_CMD_READ, b, {3'h0, c});
    @(negedge i_clk);
    t = cyc;
  endtask
  initial begin
    #(25 * 4000);
    failures++;
    results();
  end
  initial begin
    i_rst = 1'b1;
    i_dpd = 1'b0;
    repeat (4) @(posedge i_clk);
    @(negedge i_clk);
    check("mode_rst", o_mode, 16'h0000);
    check("ext_rst", o_ext_mode, 16'h2000);
    check("normal_rst", o_normal, 16'h0001);
    @(posedge i_clk);
    i_rst <= 1'b0;
    foreach (rows[r]) begin
      load(2'h0, rows[r].mr);
      check("mode", o_mode, {4'h0, rows[r].mr});
      check("normal", o_normal, 16'h0001);
      burst(rows[r].wr, r[1:0], rows[r].col);
      repeat (rows[r].n + 6) @(negedge i_clk);
      len = rows[r].n;
      check("count", q.size(), len);
      check("first", t_acc, t + 2);
      for (int i = 0; i < len && i < q.size(); i++) begin
        e.wr = rows[r].wr;
        e.bank = r[1:0];
        e.col = (rows[r].col & ~(len - 1)) | (rows[r].mr[3] ? ((rows[r].col ^ i) & (len - 1))
                : ((rows[r].col + i) & (len - 1)));
        check("acc", q[i], e);
      end
    end
    for (int m = 0; m < 4; m++) begin
      load(2'h0, {5'h00, m[2:0], 4'h0});
      t_oe = 0;
      t_rv = 0;
      burst(1'b0, 2'h0, 9'h000);
      repeat (6) @(negedge i_clk);
      check("dq_oe", t_oe, m ? t + m - 1 : 0);
      check("rd_valid", t_rv, m ? t + m : 0);
    end
    load(2'h0, 12'h024);
    burst(1'b0, 2'h0, 9'h010);
    repeat (8) @(negedge i_clk);
    check("reserved", q.size(), 16'h0000);
    load(2'h2, 12'h018);
    check("ext", o_ext_mode, 16'h2018);
    check("tsr", o_tsr, 16'h0003);
    load(2'h1, 12'hfff);
    check("bank1_ext", o_ext_mode, 16'h2018);
    check("bank1_mode", o_mode, 16'h0024);
    @(posedge i_clk);
    i_dpd <= 1'b1;
    repeat (4) @(posedge i_clk);
    i_dpd <= 1'b0;
    @(negedge i_clk);
    check("dpd_ext", o_ext_mode, 16'h2018);
    load(2'h0, 12'h027);
    burst(1'b0, 2'h3, 9'h1fe);
    repeat (6) @(negedge i_clk);
    check("full_busy", o_busy, 16'h0001);
    ctl.cmd(smbs_pkg::SMBS_CMD_STOP, 2'h0, 12'h000);
    repeat (24) @(negedge i_clk);
    check("stop_busy", o_busy, 16'h0000);
    check("stop_acc", o_acc_valid, 16'h0000);
    check("full_len", q.size() < 30, 16'h0001);
    for (int i = 0; i < 4 && i < q.size(); i++) begin
      check("full_col", q[i].col, (9'h1fe + i) & 9'h1ff);
    end
    burst(1'b0, 2'h1, 9'h020);
    repeat (3) @(negedge i_clk);
    @(posedge i_clk);
    i_rst <= 1'b1;
    @(negedge i_clk);
    check("busy_rst2", o_busy, 16'h0000);
    check("acc_rst2", o_acc_valid, 16'h0000);
    check("ext_rst2", o_ext_mode, 16'h2000);
    check("tsr_rst2", o_tsr, 16'h0000);
    @(posedge i_clk);
    i_rst <= 1'b0;
    repeat (3) @(negedge i_clk);
    check("busy_after", o_busy, 16'h0000);
    check("mode_after", o_mode, 16'h0000);
    results();
  end
endmodule
